// File: include/fpbc_defines.svh
// Constants for the flash protection and boot configuration block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef FPBC_DEFINES_SVH
`define FPBC_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define FPBC_PAGES_PER_REGION   64
`define FPBC_NUM_PAGES          1024
`define FPBC_PAGE_BYTES         256
`define FPBC_UID_BITS           128
`define FPBC_NVB_SECURITY       0
`define FPBC_NVB_BOOT_FLASH     1
`define FPBC_BOOT_ADDR          32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPBC_CLK_MHZ            100
`define FPBC_ERASE_MIN_MS       200
`define FPBC_ERASE_QUAL_CYCLES  (`FPBC_ERASE_MIN_MS * 1000 * `FPBC_CLK_MHZ)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FPBC_NVB_RESET          2'h0

`endif

// File: include/fpbc_pkg.sv
// Types for the flash protection and boot configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package fpbc_pkg;

   typedef enum logic [3:0] {
      FPBC_CMD_READ,
      FPBC_CMD_PAGE_PROG,
      FPBC_CMD_PAGE_ERASE,
      FPBC_CMD_FULL_ERASE,
      FPBC_CMD_SET_LOCK,
      FPBC_CMD_CLR_LOCK,
      FPBC_CMD_SET_NVB,
      FPBC_CMD_CLR_NVB
   } fpbc_cmd_t;

   typedef struct packed {
      fpbc_cmd_t  cmd;
      logic [9:0] page;
      logic [0:0] nvb_idx;
   } fpbc_req_t;

   typedef struct packed {
      logic done;
      logic aborted;
   } fpbc_resp_t;

endpackage

// File: design/fpbc_core.sv
// Flash protection, security and boot configuration logic.
// Assumes one command at a time from the command controller or the
// parallel port, and an array engine that reports full erase done.
//
// Overview of operation
// - One lock bit per 64-page region
// - Locked program or erase aborts, raises interrupt
// - Set and clear lock commands per region
// - Erase pin clears every lock bit
// - Security bit blocks debug and parallel accesses
// - Security bit only settable, never cleared by command
// - Erase pin plus full erase clears security
// - Calibration bits fixed, erase pin ignored
// - Fixed 128-bit unique identifier
// - Erase pin leaves identifier untouched
// - Parallel port accepts all listed commands
// - Fast mode needs test high, selects low
// - Two nonvolatile bits, set and clear commands
// - Boot at zero, flash or ROM by bit 1
// - Erase pin clears boot select bit
// - Single bank, 1024 pages of 256 bytes
// - Controller sequences program, erase, lock operations
`timescale 1ns/1ps
`default_nettype none
`include "fpbc_defines.svh"

module fpbc_core #(
   parameter int                 NUM_PAGES   = `FPBC_NUM_PAGES,
   parameter int                 REGION_PGS  = `FPBC_PAGES_PER_REGION,
   parameter int                 ERASE_QUAL  = `FPBC_ERASE_QUAL_CYCLES,
   parameter logic [127:0]       UID_VALUE   = 128'h0,  // Arbitrary value
   parameter logic [15:0]        CALIB_VALUE = 16'h0    // Arbitrary value
) (
   input  wire logic             core_clk,        // System clock
   input  wire logic             sys_rst,         // Sync reset, high
   input  wire logic             erase_pin,       // External erase pin
   input  wire logic             test_mode_pin,   // Test pin
   input  wire logic             prog_select_pin_a, // Program select A
   input  wire logic             prog_select_pin_b, // Program select B
   input  wire logic             req_valid,       // Command strobe
   input  wire fpbc_pkg::fpbc_req_t req,          // Command
   input  wire logic             full_erase_done, // Array erase complete
   output logic                  req_ready,       // Accepts command
   output fpbc_pkg::fpbc_resp_t  resp,            // Command result
   output logic                  flash_irq,       // Abort interrupt pulse
   output logic [NUM_PAGES/REGION_PGS-1:0] lock_bits, // Lock state
   output logic [1:0]            general_purpose_nv_bit, // NV bits
   output logic                  secure,          // Security active
   output logic                  debug_probe_interface_en, // Debug allowed
   output logic                  parallel_programming_port_en, // Port on
   output logic                  boot_from_flash, // Flash mapped at 0x0
   output logic [31:0]           boot_addr,       // Reset vector base
   output logic [127:0]          unique_id,       // Factory identifier
   output logic [15:0]           calib_bits       // Factory calibration
);

   localparam int NREG = NUM_PAGES / REGION_PGS;
   localparam int CW   = $clog2(ERASE_QUAL + 1);

   generate
      if (NUM_PAGES > 1024 || REGION_PGS < 1 ||
          NUM_PAGES % REGION_PGS != 0 || NREG < 1 || ERASE_QUAL < 2)
      begin : g_bad_param
         $error("fpbc_core: unsupported parameters");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // page to region
   function automatic int region_of(input logic [9:0] page);
      region_of = int'(page) / REGION_PGS;
   endfunction

   // ----------------------------------------------------------------
   // Erase pin synchroniser and qualifier
   // ----------------------------------------------------------------
   logic          erase_meta;
   logic          erase_sync;
   logic [CW-1:0] erase_cnt;
   logic          erase_qual;
   logic          erase_armed;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         erase_meta <= 1'b0;
         erase_sync <= 1'b0;
      end
      else
      begin
         erase_meta <= erase_pin;
         erase_sync <= erase_meta;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst || !erase_sync)
         erase_cnt <= '0;
      else if (erase_cnt != CW'(ERASE_QUAL))
         erase_cnt <= erase_cnt + 1'b1;
   end

   // One-cycle qualified event; a long hold fires only once
   assign erase_qual = erase_sync && (erase_cnt == CW'(ERASE_QUAL - 1));

   // arm security clear until full erase completes
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         erase_armed <= 1'b0;
      else if (erase_qual)
         erase_armed <= 1'b1;
      else if (full_erase_done)
         erase_armed <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   logic accept;
   logic is_write;
   logic hits_lock;
   int   reg_idx;

   assign req_ready = 1'b1;
   assign accept    = req_valid;
   assign reg_idx   = region_of(req.page);
   assign is_write  = (req.cmd == fpbc_pkg::FPBC_CMD_PAGE_PROG) ||
                      (req.cmd == fpbc_pkg::FPBC_CMD_PAGE_ERASE);
   assign hits_lock = (reg_idx < NREG) && lock_bits[reg_idx];

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         resp      <= '0;
         flash_irq <= 1'b0;
      end
      else
      begin
         resp.done    <= accept;
         resp.aborted <= accept && is_write && hits_lock;
         flash_irq    <= accept && is_write && hits_lock;
      end
   end

   // ----------------------------------------------------------------
   // Lock bits
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NREG; g++)
      begin : g_lock
         always_ff @(posedge core_clk)
         begin
            if (sys_rst || erase_qual)
               lock_bits[g] <= 1'b0;
            else if (accept && reg_idx == g &&
                     req.cmd == fpbc_pkg::FPBC_CMD_SET_LOCK)
               lock_bits[g] <= 1'b1;
            else if (accept && reg_idx == g &&
                     req.cmd == fpbc_pkg::FPBC_CMD_CLR_LOCK)
               lock_bits[g] <= 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // General-purpose nonvolatile bits
   // ----------------------------------------------------------------
   // security set by command, cleared by erase only
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         general_purpose_nv_bit[`FPBC_NVB_SECURITY] <= 1'b0;
      else if (accept && req.cmd == fpbc_pkg::FPBC_CMD_SET_NVB &&
               req.nvb_idx == 1'(`FPBC_NVB_SECURITY))
         general_purpose_nv_bit[`FPBC_NVB_SECURITY] <= 1'b1;
      else if (erase_armed && full_erase_done)
         general_purpose_nv_bit[`FPBC_NVB_SECURITY] <= 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst || erase_qual)
         general_purpose_nv_bit[`FPBC_NVB_BOOT_FLASH] <= 1'b0;
      else if (accept && req.nvb_idx == 1'(`FPBC_NVB_BOOT_FLASH) &&
               req.cmd == fpbc_pkg::FPBC_CMD_SET_NVB)
         general_purpose_nv_bit[`FPBC_NVB_BOOT_FLASH] <= 1'b1;
      else if (accept && req.nvb_idx == 1'(`FPBC_NVB_BOOT_FLASH) &&
               req.cmd == fpbc_pkg::FPBC_CMD_CLR_NVB)
         general_purpose_nv_bit[`FPBC_NVB_BOOT_FLASH] <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Access gating and boot map
   // ----------------------------------------------------------------
   logic       fast_mode;
   logic [2:0] strap_meta;
   logic [2:0] strap_sync;

   // Strap pins are asynchronous levels; two flops before any decode
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         strap_meta <= 3'h0;
         strap_sync <= 3'h0;
      end
      else
      begin
         strap_meta <= {test_mode_pin, prog_select_pin_a, prog_select_pin_b};
         strap_sync <= strap_meta;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         fast_mode <= 1'b0;
      else
         fast_mode <= strap_sync[2] && !strap_sync[1] && !strap_sync[0];
   end

   assign secure = general_purpose_nv_bit[`FPBC_NVB_SECURITY];
   // security blocks debug and parallel port
   assign debug_probe_interface_en     = !secure;
   assign parallel_programming_port_en = fast_mode && !secure;
   assign boot_from_flash = general_purpose_nv_bit[`FPBC_NVB_BOOT_FLASH];
   assign boot_addr       = `FPBC_BOOT_ADDR;
   assign unique_id  = UID_VALUE;
   assign calib_bits = CALIB_VALUE;

endmodule
`default_nettype wire

// File: dv/fpbc_properties.sv
// Port checker for fpbc_core, attached by bind.
// Assumes commands arrive only while the erase pin is low.
`timescale 1ns/1ps
`default_nettype none
module fpbc_chk #(
   parameter int NUM_PAGES  = 1024,
   parameter int REGION_PGS = 64,
   parameter int ERASE_QUAL = 16
) (
   input wire logic                 core_clk,  // Clock
   input wire logic                 sys_rst,   // Reset
   input wire logic                 erase_pin, // Erase
   input wire logic                 req_valid, // Strobe
   input wire fpbc_pkg::fpbc_req_t  req,       // Command
   input wire logic                 full_erase_done, // Done
   input wire fpbc_pkg::fpbc_resp_t resp,      // Result
   input wire logic                 flash_irq, // Irq
   input wire logic [NUM_PAGES/REGION_PGS-1:0] lock_bits, // Locks
   input wire logic [1:0]           general_purpose_nv_bit, // Bits
   input wire logic                 secure,    // Security
   input wire logic                 debug_probe_interface_en, // Debug
   input wire logic                 parallel_programming_port_en // Port
);
   logic pe;
   int   hi;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   assign pe = req_valid && !erase_pin &&
      (req.cmd == fpbc_pkg::FPBC_CMD_PAGE_PROG ||
       req.cmd == fpbc_pkg::FPBC_CMD_PAGE_ERASE);
   // Saturating count of erase pin high time
   always_ff @(posedge core_clk)
      hi <= (sys_rst || !erase_pin) ? 0 : hi + int'(hi < ERASE_QUAL + 9);
   a_cmd_done: assert property (req_valid |=> resp.done)
      else $error("command not answered");
   a_lock_abort: assert property (pe && lock_bits[req.page / REGION_PGS]
      |=> resp.aborted) else $error("locked command not aborted");
   a_irq_match: assert property (flash_irq == resp.aborted)
      else $error("interrupt differs from abort");
   a_set_lock: assert property (req_valid && !erase_pin &&
      req.cmd == fpbc_pkg::FPBC_CMD_SET_LOCK
      |=> lock_bits[$past(req.page) / REGION_PGS]) else $error("lock not set");
   a_sec_set: assert property (req_valid && !req.nvb_idx &&
      req.cmd == fpbc_pkg::FPBC_CMD_SET_NVB |=> secure)
      else $error("security not set");
   a_sec_hold: assert property ($fell(secure) && !$past(sys_rst)
      |-> $past(full_erase_done)) else $error("security cleared early");
   a_access_block: assert property (debug_probe_interface_en != secure &&
      !(secure && parallel_programming_port_en)) else $error("access leak");
   a_erase_clear: assert property (hi == ERASE_QUAL + 8 |->
      lock_bits == '0 && !general_purpose_nv_bit[1]) else $error("no clear");
   c_abort: cover property (resp.aborted);
   c_unsecure: cover property ($fell(secure));
   c_port_on: cover property (parallel_programming_port_en);
endmodule
bind fpbc_core fpbc_chk #(.NUM_PAGES(NUM_PAGES), .REGION_PGS(REGION_PGS),
   .ERASE_QUAL(ERASE_QUAL)) i_chk (.core_clk, .sys_rst, .erase_pin, .req_valid,
   .req, .full_erase_done, .resp, .flash_irq, .lock_bits,
   .general_purpose_nv_bit, .secure, .debug_probe_interface_en,
   .parallel_programming_port_en);
`default_nettype wire

// File: dv/fpbc_array_model.sv
// Array engine stand-in: reports a full erase after a delay.
// Assumes the command strobe and struct of fpbc_core.
`timescale 1ns/1ps
`default_nettype none
module fpbc_array_model #(
   parameter int DELAY = 5
) (
   input  wire logic                core_clk,       // Clock
   input  wire logic                sys_rst,        // Reset
   input  wire logic                req_valid,      // Strobe
   input  wire fpbc_pkg::fpbc_req_t req,            // Command
   output logic                     full_erase_done // Done pulse
);
   int cnt;
   always_ff @(posedge core_clk)
   begin
      full_erase_done <= !sys_rst && cnt == 1;
      if (sys_rst)
         cnt <= 0;
      else if (req_valid && req.cmd == fpbc_pkg::FPBC_CMD_FULL_ERASE)
         cnt <= DELAY;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

// File: dv/fpbc_core_tb_top.sv
// Self-checking bench for fpbc_core with a short erase qualifier.
// Assumes the array model answers a full erase within ten cycles.
`timescale 1ns/1ps
`default_nettype none
module fpbc_core_tb_top;
   localparam int QUAL = 16;
   // Arbitrary factory values, nonzero so a cleared output shows up
   localparam logic [127:0] UID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [15:0]  CAL = 16'hA5C3;
   logic core_clk = 1'h0, sys_rst = 1'h1, erase_pin = 1'h0, req_valid = 1'h0;
   logic test_mode_pin = 1'h0, prog_select_pin_a = 1'h0, prog_select_pin_b = 1'h0;
   logic full_erase_done, req_ready, flash_irq, secure, dbg_en, port_en, boot_fl;
   fpbc_pkg::fpbc_req_t  req = '0;
   fpbc_pkg::fpbc_resp_t resp;
   logic [15:0]  lock_bits, calib_bits, exp_lock = 16'h0;
   logic [1:0]   nvb;
   logic [31:0]  boot_addr;
   logic [127:0] unique_id;
   int n_mismatch = 0, tests_run = 0;
   always #5 core_clk = ~core_clk;
   fpbc_core #(.ERASE_QUAL(QUAL), .UID_VALUE(UID), .CALIB_VALUE(CAL))
      i_dut (.core_clk, .sys_rst, .erase_pin,
      .test_mode_pin, .prog_select_pin_a, .prog_select_pin_b, .req_valid, .req,
      .full_erase_done, .req_ready, .resp, .flash_irq, .lock_bits, .secure,
      .general_purpose_nv_bit(nvb), .debug_probe_interface_en(dbg_en),
      .parallel_programming_port_en(port_en), .boot_from_flash(boot_fl),
      .boot_addr, .unique_id, .calib_bits);
   fpbc_array_model i_arr (.core_clk, .sys_rst, .req_valid, .req,
      .full_erase_done);
   task automatic chk(input logic [127:0] s, e, input string n);
      tests_run++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic send(input fpbc_pkg::fpbc_cmd_t c, input logic [9:0] p,
      input logic [0:0] i);
      @(posedge core_clk);
      req_valid <= 1'h1;
      req <= '{c, p, i};
      @(posedge core_clk);
      req_valid <= 1'h0;
      #1;
   endtask
   function automatic logic exp_abort(fpbc_pkg::fpbc_cmd_t c, logic [9:0] p);
      return exp_lock[p / 64] && (c == fpbc_pkg::FPBC_CMD_PAGE_PROG ||
         c == fpbc_pkg::FPBC_CMD_PAGE_ERASE);
   endfunction
   task automatic step(input fpbc_pkg::fpbc_cmd_t c, input logic [9:0] p);
      logic a;
      a = exp_abort(c, p);
      send(c, p, 1'h0);
      chk(resp, {1'h1, a}, "resp");
      chk(flash_irq, a, "irq");
      chk(req_ready, 1'h1, "ready");
      if (c == fpbc_pkg::FPBC_CMD_SET_LOCK || c == fpbc_pkg::FPBC_CMD_CLR_LOCK)
         exp_lock[p / 64] = (c == fpbc_pkg::FPBC_CMD_SET_LOCK);
      chk(lock_bits, exp_lock, "locks");
   endtask
   initial
   begin
      void'($urandom(32'h634D));
      idle(15);
      @(posedge core_clk) sys_rst <= 1'h0;
      idle(1);
      chk({lock_bits, nvb, dbg_en}, 19'h1, "reset");
      chk(boot_addr, 32'h0, "boot addr");
      // Region edges first: last page, first page of a region, one below
      step(fpbc_pkg::FPBC_CMD_SET_LOCK, 10'h3FF);
      step(fpbc_pkg::FPBC_CMD_PAGE_ERASE, 10'h3C0);
      step(fpbc_pkg::FPBC_CMD_PAGE_PROG, 10'h3BF);
      for (int k = 0; k < 60; k++)
         step(fpbc_pkg::fpbc_cmd_t'($urandom_range(5)), 10'($urandom));
      // A short pulse must not pass the qualifier
      @(posedge core_clk) erase_pin <= 1'h1;
      idle(QUAL / 2);
      @(posedge core_clk) erase_pin <= 1'h0;
      idle(8);
      chk(lock_bits, exp_lock, "glitch");
      send(fpbc_pkg::FPBC_CMD_SET_NVB, 10'h0, 1'h1);
      chk(boot_fl, 1'h1, "boot");
      send(fpbc_pkg::FPBC_CMD_CLR_NVB, 10'h0, 1'h1);
      chk(boot_fl, 1'h0, "boot");
      send(fpbc_pkg::FPBC_CMD_SET_NVB, 10'h0, 1'h1);
      @(posedge core_clk) test_mode_pin <= 1'h1;
      idle(8);
      chk(port_en, 1'h1, "port");
      @(posedge core_clk) prog_select_pin_b <= 1'h1;
      idle(8);
      chk(port_en, 1'h0, "port");
      @(posedge core_clk) prog_select_pin_b <= 1'h0;
      send(fpbc_pkg::FPBC_CMD_SET_NVB, 10'h0, 1'h0);
      send(fpbc_pkg::FPBC_CMD_CLR_NVB, 10'h0, 1'h0);
      send(fpbc_pkg::FPBC_CMD_FULL_ERASE, 10'h0, 1'h0);
      idle(10);
      chk({secure, dbg_en, port_en}, 3'h4, "secure");
      // pin held well past the qualifier
      @(posedge core_clk) erase_pin <= 1'h1;
      idle(QUAL + 20);
      @(posedge core_clk) erase_pin <= 1'h0;
      idle(4);
      chk({lock_bits, nvb, calib_bits}, {18'h1, CAL}, "erase");
      chk(unique_id, UID, "uid");
      send(fpbc_pkg::FPBC_CMD_FULL_ERASE, 10'h0, 1'h0);
      idle(10);
      chk({secure, dbg_en}, 2'h1, "unsecure");
      print_verdict();
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      print_verdict();
   end
endmodule
`default_nettype wire
